// file: design/busy_timer.sv
// down counter that holds the busy interval
`timescale 1ns/1ps
module busy_timer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [15:0] load,
  output logic running
);
  logic [15:0] count; // cycles left
  logic [15:0] next_count;
  // load on start, else count down to zero
  always_comb begin
    next_count = count;
    if (start) begin
      next_count = load;
    end else if (count != 16'h0000) begin
      next_count = count - 16'h0001;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count <= 16'h0000;
    end else begin
      count <= next_count;
    end
  end
  assign running = (count != 16'h0000);
endmodule

// file: design/char_lcd_instruction_port.sv
// instruction and data port of a 24x2 character display controller
`timescale 1ns/1ps
`include "lcd_map.svh"
module char_lcd_instruction_port #(
  parameter int osc_khz = `LCD_OSC_KHZ, // actual oscillator rate
  parameter int long_busy_cycles = `LCD_LONG_CYC(`LCD_OSC_KHZ) // clear/home busy
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic target_select, // pin: high data ram, low instruction
  input wire logic rw_dir, // pin: high read, low write
  input wire logic strobe, // pin: enable strobe
  input wire logic [7:0] bus_in, // pin data lines, bus_line_top is bit 7
  output logic [7:0] bus_out,
  output logic bus_oe, // high while driving the data lines
  input wire logic view_line, // screen scan: 0 first line
  input wire logic [4:0] view_col, // screen scan: column 0..23
  output logic [7:0] view_char, // text code shown there
  output logic busy_indicator,
  output logic [6:0] address_counter,
  output logic increment,
  output logic whole_display_shift_enable,
  output logic display_on,
  output logic cursor_on,
  output logic blink_on,
  output logic bus_width_select,
  output logic two_line,
  output logic font_tall,
  output logic [5:0] display_shift
);
  // ****************************************
  // pin capture and strobe edges
  // ****************************************
  logic [10:0] pins; // synced {select, dir, strobe, data}
  logic strobe_prev; // last synced strobe
  logic s_sel, s_dir, s_e;
  logic [7:0] s_bus;
  pin_sync #(.W(11)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({target_select, rw_dir, strobe, bus_in}),
    .q(pins)
  );
  assign {s_sel, s_dir, s_e, s_bus} = pins;
  wire e_rise = s_e & ~strobe_prev;
  wire e_fall = ~s_e & strobe_prev;
  // ****************************************
  // memories
  // ****************************************
  logic [7:0] text_ram [0:127]; // display_text_ram, 7-bit address
  logic [7:0] glyph_ram [0:63]; // glyph_pattern_ram
  // ****************************************
  // helpers
  // ****************************************
  // opcode by highest set bit, low bits are operands
  function automatic lcd_pkg::cmd_t decode(input logic [7:0] b);
    if (b[7]) return lcd_pkg::CMD_TEXT_ADDR;
    else if (b[6]) return lcd_pkg::CMD_GLYPH_ADDR;
    else if (b[5]) return lcd_pkg::CMD_FUNC;
    else if (b[4]) return lcd_pkg::CMD_SHIFT;
    else if (b[3]) return lcd_pkg::CMD_ONOFF;
    else if (b[2]) return lcd_pkg::CMD_ENTRY;
    else if (b[1]) return lcd_pkg::CMD_HOME;
    else if (b[0]) return lcd_pkg::CMD_CLEAR;
    else return lcd_pkg::CMD_NONE;
  endfunction
  // one step of the counter, up or down
  function automatic logic [6:0] step(input logic [6:0] a, input logic up);
    return up ? a + 7'h01 : a - 7'h01;
  endfunction
  // shift offset kept inside one line span
  function automatic logic [5:0] shift_step(input logic [5:0] s, input logic up);
    if (up) return (s == `LCD_LINE_SPAN - 6'h01) ? 6'h00 : s + 6'h01;
    else return (s == 6'h00) ? `LCD_LINE_SPAN - 6'h01 : s - 6'h01;
  endfunction
  // ****************************************
  // controller state
  // ****************************************
  lcd_pkg::state_t state, next_state;
  logic to_glyph, next_to_glyph; // data path goes to glyph ram
  logic nib_low, next_nib_low; // next nibble is the low one
  logic [3:0] nib_hi, next_nib_hi; // held high nibble of a write
  logic [7:0] rd_byte, next_rd_byte; // byte being read out
  logic [6:0] fill_idx, next_fill_idx;
  logic [7:0] next_bus_out;
  logic next_bus_oe, next_busy;
  logic [6:0] next_ac;
  logic next_inc, next_sh, next_don, next_con, next_bon;
  logic next_dl, next_n, next_f;
  logic [5:0] next_shift;
  logic [7:0] next_view;
  logic text_we, glyph_we; // ram write strobes
  logic [6:0] text_wa;
  logic [7:0] ram_wd;
  logic tmr_start, tmr_run;
  logic [15:0] tmr_load;
  logic [7:0] wr_byte; // completed write byte
  logic wr_done; // a whole byte has been written
  logic accept; // byte accepted while not busy
  logic rd_last; // strobe fall ends the last nibble of a read
  lcd_pkg::cmd_t cmd;
  // busy interval, scaled to the oscillator
  localparam logic [15:0] SHORT_CYC = 16'(`LCD_SHORT_CYC(osc_khz));
  localparam logic [15:0] LONG_CYC = 16'(long_busy_cycles * `LCD_OSC_KHZ / osc_khz);
  busy_timer u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .start(tmr_start),
    .load(tmr_load),
    .running(tmr_run)
  );
  // next values for all control state
  always_comb begin
    next_state = state;
    next_to_glyph = to_glyph;
    next_nib_low = nib_low;
    next_nib_hi = nib_hi;
    next_rd_byte = rd_byte;
    next_fill_idx = fill_idx;
    next_bus_out = bus_out;
    next_bus_oe = bus_oe;
    next_ac = address_counter;
    next_inc = increment;
    next_sh = whole_display_shift_enable;
    next_don = display_on;
    next_con = cursor_on;
    next_bon = blink_on;
    next_dl = bus_width_select;
    next_n = two_line;
    next_f = font_tall;
    next_shift = display_shift;
    text_we = 1'b0;
    glyph_we = 1'b0;
    text_wa = address_counter;
    ram_wd = 8'h00;
    tmr_start = 1'b0;
    tmr_load = SHORT_CYC;
    wr_byte = s_bus;
    wr_done = 1'b0;
    rd_last = 1'b0;
    // write side: byte latched on strobe fall
    if (e_fall && !s_dir) begin
      if (bus_width_select) begin
        wr_done = 1'b1;
      end else if (!nib_low) begin
        next_nib_hi = s_bus[7:4];
        next_nib_low = 1'b1;
      end else begin
        wr_byte = {nib_hi, s_bus[7:4]};
        wr_done = 1'b1;
        next_nib_low = 1'b0;
      end
    end
    // read side: drive while strobe is high
    if (e_rise && s_dir) begin
      if (!nib_low) begin
        next_rd_byte = s_sel ? (to_glyph ? glyph_ram[address_counter[5:0]] : text_ram[address_counter])
                             : {busy_indicator, address_counter};
        next_bus_out = next_rd_byte;
        if (!bus_width_select) begin
          next_bus_out = {next_rd_byte[7:4], 4'h0};
        end
      end else begin
        next_bus_out = {rd_byte[3:0], 4'h0};
      end
      next_bus_oe = 1'b1;
    end
    if (e_fall && s_dir) begin
      next_bus_oe = 1'b0;
      rd_last = bus_width_select | nib_low;
      next_nib_low = bus_width_select ? 1'b0 : ~nib_low;
    end
    accept = (state == lcd_pkg::ST_IDLE);
    cmd = decode(wr_byte);
    // data read costs a step and a short busy; status costs nothing
    if (rd_last && s_sel && accept) begin
      next_ac = step(address_counter, increment);
      tmr_start = 1'b1;
      next_state = lcd_pkg::ST_RUN;
    end else if (wr_done && accept && s_sel) begin
      ram_wd = wr_byte;
      text_we = ~to_glyph;
      glyph_we = to_glyph;
      next_ac = step(address_counter, increment);
      if (whole_display_shift_enable && !to_glyph) begin
        next_shift = shift_step(display_shift, increment);
      end
      tmr_start = 1'b1;
      next_state = lcd_pkg::ST_RUN;
    end else if (wr_done && accept && cmd != lcd_pkg::CMD_NONE) begin
      tmr_start = 1'b1;
      next_state = lcd_pkg::ST_RUN;
      case (cmd)
        lcd_pkg::CMD_CLEAR: begin
          next_ac = `LCD_HOME_ADDR;
          next_inc = 1'b1;
          next_to_glyph = 1'b0;
          next_fill_idx = 7'h00;
          tmr_load = LONG_CYC;
          next_state = lcd_pkg::ST_FILL;
        end
        lcd_pkg::CMD_HOME: begin
          next_ac = `LCD_HOME_ADDR;
          next_shift = 6'h00;
          next_to_glyph = 1'b0;
          tmr_load = LONG_CYC;
        end
        lcd_pkg::CMD_ENTRY: begin
          next_inc = wr_byte[`LCD_BIT_ID];
          next_sh = wr_byte[`LCD_BIT_SH];
        end
        lcd_pkg::CMD_ONOFF: begin
          next_don = wr_byte[`LCD_BIT_DISP];
          next_con = wr_byte[`LCD_BIT_CUR];
          next_bon = wr_byte[`LCD_BIT_BLINK];
        end
        lcd_pkg::CMD_SHIFT: begin
          if (wr_byte[`LCD_BIT_SC]) begin
            next_shift = shift_step(display_shift, wr_byte[`LCD_BIT_RL]);
          end else begin
            next_ac = step(address_counter, wr_byte[`LCD_BIT_RL]);
          end
        end
        lcd_pkg::CMD_FUNC: begin
          next_dl = wr_byte[`LCD_BIT_DL];
          next_n = wr_byte[`LCD_BIT_N];
          next_f = wr_byte[`LCD_BIT_F];
        end
        lcd_pkg::CMD_GLYPH_ADDR: begin
          next_ac = {1'b0, wr_byte[5:0]};
          next_to_glyph = 1'b1;
        end
        lcd_pkg::CMD_TEXT_ADDR: begin
          next_ac = wr_byte[6:0];
          next_to_glyph = 1'b0;
        end
        default: begin
          next_state = lcd_pkg::ST_RUN;
        end
      endcase
    end
    // clear fills one text location per cycle
    case (state)
      lcd_pkg::ST_FILL: begin
        text_we = 1'b1;
        text_wa = fill_idx;
        ram_wd = `LCD_SPACE_CODE;
        next_fill_idx = fill_idx + 7'h01;
        if (fill_idx == `LCD_FILL_LAST) begin
          next_state = lcd_pkg::ST_RUN;
        end
      end
      lcd_pkg::ST_RUN: begin
        if (!tmr_run && !tmr_start) begin
          next_state = lcd_pkg::ST_IDLE;
        end
      end
      lcd_pkg::ST_IDLE: begin
        text_wa = address_counter;
      end
      default: begin
        next_state = lcd_pkg::ST_IDLE;
      end
    endcase
    next_busy = (next_state != lcd_pkg::ST_IDLE);
    // screen position to text address, shift applied within the line
    begin
      logic [5:0] col;
      col = 6'(view_col) + display_shift;
      if (col >= `LCD_LINE_SPAN) begin
        col = col - `LCD_LINE_SPAN;
      end
      next_view = text_ram[(view_line ? `LCD_LINE2_BASE : 7'h00) + 7'(col)];
    end
  end
  // registers only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= lcd_pkg::ST_IDLE;
      strobe_prev <= 1'b0;
      to_glyph <= 1'b0;
      nib_low <= 1'b0;
      nib_hi <= 4'h0;
      rd_byte <= 8'h00;
      fill_idx <= 7'h00;
      bus_out <= 8'h00;
      bus_oe <= 1'b0;
      busy_indicator <= 1'b0;
      address_counter <= `LCD_HOME_ADDR;
      increment <= 1'b1;
      whole_display_shift_enable <= 1'b0;
      display_on <= 1'b0;
      cursor_on <= 1'b0;
      blink_on <= 1'b0;
      bus_width_select <= 1'b1; // full width until told otherwise
      two_line <= 1'b0;
      font_tall <= 1'b0;
      display_shift <= 6'h00;
      view_char <= 8'h00;
    end else begin
      state <= next_state;
      strobe_prev <= s_e;
      to_glyph <= next_to_glyph;
      nib_low <= next_nib_low;
      nib_hi <= next_nib_hi;
      rd_byte <= next_rd_byte;
      fill_idx <= next_fill_idx;
      bus_out <= next_bus_out;
      bus_oe <= next_bus_oe;
      busy_indicator <= next_busy;
      address_counter <= next_ac;
      increment <= next_inc;
      whole_display_shift_enable <= next_sh;
      display_on <= next_don;
      cursor_on <= next_con;
      blink_on <= next_bon;
      bus_width_select <= next_dl;
      two_line <= next_n;
      font_tall <= next_f;
      display_shift <= next_shift;
      view_char <= next_view;
    end
  end
  // ram write ports, contents need no reset
  always_ff @(posedge clk) begin
    if (text_we) begin
      text_ram[text_wa] <= ram_wd;
    end
    if (glyph_we) begin
      glyph_ram[address_counter[5:0]] <= ram_wd;
    end
  end
  // ****************************************
  // checks
  // ****************************************
  wire cmd_go = wr_done && accept && !s_sel && cmd != lcd_pkg::CMD_NONE;
  // short busy window follows the oscillator rate, a little slack for the state hand-off
  localparam int short_min = `LCD_SHORT_CYC(osc_khz) - 2;
  localparam int short_max = `LCD_SHORT_CYC(osc_khz) + 2;
  busy_on_cmd_a: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_go |=> busy_indicator) else $error("busy not raised");
  clear_home_a: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_go && cmd == lcd_pkg::CMD_CLEAR |=> address_counter == 7'h00 ##128 busy_indicator)
    else $error("clear did not home or end early");
  entry_time_a: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_go && cmd == lcd_pkg::CMD_ENTRY |=> busy_indicator ##[short_min:short_max] !busy_indicator)
    else $error("short busy out of range");
  write_step_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_done && accept && s_sel |=> address_counter == $past(address_counter) + 7'h01 || !increment)
    else $error("counter did not step");
  status_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    e_rise && s_dir && !s_sel && bus_width_select && !nib_low
    |=> bus_out == {$past(busy_indicator), $past(address_counter)} && bus_oe)
    else $error("status read wrong");
  oe_drop_a: assert property (@(posedge clk) disable iff (!rst_n)
    e_fall |=> !bus_oe) else $error("bus still driven");
  width_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_go && cmd == lcd_pkg::CMD_FUNC |=> bus_width_select == $past(wr_byte[4]))
    else $error("width not latched");
  text_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_go && cmd == lcd_pkg::CMD_TEXT_ADDR |=> address_counter == $past(wr_byte[6:0]) && !to_glyph)
    else $error("text address not loaded");
endmodule

// file: design/lcd_map.svh
// offsets, field positions, reset values and timing counts of the instruction port
`ifndef LCD_MAP_SVH
`define LCD_MAP_SVH
// ****************************************
// timing
// ****************************************
`define LCD_CLK_KHZ 20000
`define LCD_OSC_KHZ 270
`define LCD_SHORT_US 38
`define LCD_LONG_US 1520
`define LCD_SHORT_CYC(osc) ((`LCD_SHORT_US * `LCD_CLK_KHZ / 1000) * `LCD_OSC_KHZ / (osc))
`define LCD_LONG_CYC(osc) ((`LCD_LONG_US * `LCD_CLK_KHZ / 1000) * `LCD_OSC_KHZ / (osc))
// ****************************************
// values and field positions
// ****************************************
`define LCD_SPACE_CODE 8'h20
`define LCD_HOME_ADDR 7'h00
`define LCD_LINE2_BASE 7'h40
`define LCD_LINE_SPAN 6'h28
`define LCD_FILL_LAST 7'h7f
`define LCD_BIT_ID 1
`define LCD_BIT_SH 0
`define LCD_BIT_DISP 2
`define LCD_BIT_CUR 1
`define LCD_BIT_BLINK 0
`define LCD_BIT_SC 3
`define LCD_BIT_RL 2
`define LCD_BIT_DL 4
`define LCD_BIT_N 3
`define LCD_BIT_F 2
`endif

// file: design/lcd_pkg.sv
// types shared by the instruction port
package lcd_pkg;
  // decoded instruction, by highest set bit
  typedef enum logic [3:0] {
    CMD_NONE, CMD_CLEAR, CMD_HOME, CMD_ENTRY, CMD_ONOFF,
    CMD_SHIFT, CMD_FUNC, CMD_GLYPH_ADDR, CMD_TEXT_ADDR
  } cmd_t;
  // controller states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FILL = 3'b010,
    ST_RUN = 3'b100
  } state_t;
endpackage

// file: design/pin_sync.sv
// two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module pin_sync #(parameter int W = 1) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta; // first stage, read only by q
  // two flops, only q looks at meta
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// file: tb/char_lcd_instruction_port_tb.sv
// self-checking bench for the character display instruction port
`timescale 1ns/1ps
`include "lcd_map.svh"
module char_lcd_instruction_port_tb;
  localparam int osc = 540; // doubled oscillator halves every short count
  localparam int long_cyc = 400; // shortened clear/home count, scaled count must still outlast the fill
  localparam int long_exp = long_cyc * `LCD_OSC_KHZ / osc; // busy cycles after oscillator scaling
  localparam int short_cyc = `LCD_SHORT_CYC(osc);
  logic clk, rst_n, narrow, view_line;
  logic target_select, rw_dir, strobe, bus_oe, busy_indicator;
  logic [7:0] bus_in, bus_out, view_char, r;
  logic [4:0] view_col;
  logic [6:0] address_counter;
  logic [5:0] display_shift;
  logic increment, whole_display_shift_enable, display_on, cursor_on, blink_on;
  logic bus_width_select, two_line, font_tall, ok;
  int err_total, checked, busy_cyc;
  char_lcd_instruction_port #(.osc_khz(osc), .long_busy_cycles(long_cyc)) i_dut (.clk(clk), .rst_n(rst_n),
    .target_select(target_select), .rw_dir(rw_dir), .strobe(strobe), .bus_in(bus_in), .bus_out(bus_out),
    .bus_oe(bus_oe), .view_line(view_line), .view_col(view_col), .view_char(view_char),
    .busy_indicator(busy_indicator), .address_counter(address_counter), .increment(increment),
    .whole_display_shift_enable(whole_display_shift_enable), .display_on(display_on), .cursor_on(cursor_on),
    .blink_on(blink_on), .bus_width_select(bus_width_select), .two_line(two_line), .font_tall(font_tall),
    .display_shift(display_shift));
  lcd_host i_host (.clk(clk), .narrow(narrow), .target_select(target_select), .rw_dir(rw_dir),
    .strobe(strobe), .bus_in(bus_in), .bus_out(bus_out), .bus_oe(bus_oe));
  // ****************************************
  // clock and busy length meter
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // counts busy cycles since the bench last zeroed it
  always @(posedge clk) begin
    if (busy_indicator === 1'b1) busy_cyc++;
  end
  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // poll until idle; a flag that never clears ends the run
  task automatic settle;
    i_host.wait_idle(ok);
    check({7'h00, ok}, 8'h01);
    if (!ok) close_out();
  endtask
  task automatic cmd(input logic [7:0] c);
    i_host.op(1'b0, 1'b0, c, r);
    settle();
  endtask
  task automatic wr(input logic [7:0] d);
    i_host.op(1'b1, 1'b0, d, r);
    settle();
  endtask
  task automatic rd(output logic [7:0] d);
    i_host.op(1'b1, 1'b1, 8'h00, d);
    settle();
  endtask
  // screen scan lookup, answered one cycle later
  task automatic view(input logic ln, input logic [4:0] col, output logic [7:0] v);
    @(negedge clk);
    view_line = ln;
    view_col = col;
    @(negedge clk);
    v = view_char;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    err_total = 0;
    checked = 0;
    busy_cyc = 0;
    rst_n = 1'b0;
    narrow = 1'b0;
    view_line = 1'b0;
    view_col = 5'h00;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    check({1'h0, address_counter}, 8'h00);
    check({3'h0, increment, bus_width_select, display_on, busy_indicator, bus_oe}, 8'h18);
    busy_cyc = 0;
    cmd(8'h01);
    check({7'h00, busy_cyc >= long_exp && busy_cyc <= long_exp + 2}, 8'h01);
    view(1'b1, 5'h00, r);
    check(r, 8'h20);
    cmd(8'h3f);
    check({5'h00, bus_width_select, two_line, font_tall}, 8'h07);
    cmd(8'h0e);
    check({5'h00, display_on, cursor_on, blink_on}, 8'h06);
    busy_cyc = 0;
    cmd(8'h06);
    check({6'h00, increment, whole_display_shift_enable}, 8'h02);
    check({7'h00, busy_cyc >= short_cyc && busy_cyc <= short_cyc + 2}, 8'h01);
    cmd(8'hc0);
    check({1'h0, address_counter}, 8'h40);
    // status straight after a write shows busy and the stepped counter
    i_host.op(1'b1, 1'b0, 8'h41, r);
    i_host.op(1'b0, 1'b1, 8'h00, r);
    check(r, 8'hc1);
    settle();
    check({7'h00, busy_indicator}, 8'h00);
    // second write issued while busy must be dropped
    i_host.op(1'b1, 1'b0, 8'h42, r);
    i_host.op(1'b1, 1'b0, 8'h43, r);
    settle();
    check({1'h0, address_counter}, 8'h42);
    view(1'b1, 5'h01, r);
    check(r, 8'h42);
    cmd(8'hd7);
    wr(8'h5a);
    view(1'b1, 5'h17, r);
    check(r, 8'h5a);
    cmd(8'h97);
    wr(8'h33);
    view(1'b0, 5'h17, r);
    check(r, 8'h33);
    cmd(8'hc0);
    rd(r);
    check(r, 8'h41);
    check({1'h0, address_counter}, 8'h41);
    cmd(8'h04);
    cmd(8'hc1);
    wr(8'h55);
    check({1'h0, address_counter}, 8'h40);
    cmd(8'h06);
    cmd(8'h14);
    check({1'h0, address_counter}, 8'h41);
    cmd(8'h10);
    check({1'h0, address_counter}, 8'h40);
    cmd(8'h1c);
    check({7'h00, display_shift != 6'h00}, 8'h01);
    check({1'h0, address_counter}, 8'h40);
    cmd(8'h03);
    check({2'h0, display_shift}, 8'h00);
    check({1'h0, address_counter}, 8'h00);
    cmd(8'hc1);
    rd(r);
    check(r, 8'h55);
    cmd(8'h45);
    check({1'h0, address_counter}, 8'h05);
    wr(8'h1f);
    view(1'b0, 5'h05, r);
    check(r, 8'h20);
    cmd(8'h45);
    rd(r);
    check(r, 8'h1f);
    // narrow width: the switch lands mid-command, so the host follows before polling
    i_host.op(1'b0, 1'b0, 8'h28, r);
    narrow = 1'b1;
    settle();
    check({7'h00, bus_width_select}, 8'h00);
    cmd(8'h80);
    wr(8'h9c);
    cmd(8'h80);
    rd(r);
    check(r, 8'h9c);
    view(1'b0, 5'h00, r);
    check(r, 8'h9c);
    i_host.op(1'b0, 1'b0, 8'h38, r);
    narrow = 1'b0;
    settle();
    check({7'h00, bus_width_select}, 8'h01);
    close_out();
  end
endmodule

// file: tb/lcd_host.sv
// host processor model that drives the display's strobed pin bus
`timescale 1ns/1ps
module lcd_host (
  input wire logic clk,
  input wire logic narrow,
  output logic target_select,
  output logic rw_dir,
  output logic strobe,
  output logic [7:0] bus_in,
  input wire logic [7:0] bus_out,
  input wire logic bus_oe
);
  logic [7:0] drive; // value the host puts on the lines
  logic host_oe; // host owns the lines
  logic [7:0] last; // last level seen on the lines
  // ****************************************
  // data line resolution
  // ****************************************
  // released lines show the inverse of the last level, so stale data never reads as valid
  always_comb begin
    if (bus_oe) begin
      bus_in = bus_out;
    end else if (host_oe) begin
      bus_in = drive;
    end else begin
      bus_in = ~last;
    end
  end
  // history of the lines for the released pattern
  always @(posedge clk) begin
    last <= bus_in;
  end
  initial begin
    target_select = 1'b0;
    rw_dir = 1'b0;
    strobe = 1'b0;
    drive = 8'h00;
    host_oe = 1'b0;
    last = 8'h00;
  end
  // ****************************************
  // bus cycles
  // ****************************************
  // one strobe pulse; select and direction settle before the rise and hold past the fall
  task automatic pulse(input logic rs, input logic rw, input logic [7:0] w, output logic [7:0] r);
    @(negedge clk);
    target_select = rs;
    rw_dir = rw;
    host_oe = !rw;
    drive = w;
    repeat (2) @(negedge clk);
    strobe = 1'b1;
    repeat (6) @(negedge clk);
    r = bus_out;
    strobe = 1'b0;
    repeat (6) @(negedge clk);
    host_oe = 1'b0;
  endtask
  // whole byte; narrow width sends the high nibble first on the top lines
  task automatic op(input logic rs, input logic rw, input logic [7:0] w, output logic [7:0] r);
    logic [7:0] hi;
    logic [7:0] lo;
    if (narrow) begin
      pulse(rs, rw, {w[7:4], 4'h0}, hi);
      pulse(rs, rw, {w[3:0], 4'h0}, lo);
      r = {hi[7:4], lo[7:4]};
    end else begin
      pulse(rs, rw, w, r);
    end
  endtask
  // poll status until the top bit reads low, bounded so a stuck flag cannot hang
  task automatic wait_idle(output logic ok);
    logic [7:0] s;
    ok = 1'b0;
    for (int i = 0; i < 200 && !ok; i++) begin
      op(1'b0, 1'b1, 8'h00, s);
      ok = (s[7] === 1'b0);
    end
  endtask
endmodule
